// File: src/lgx_global_ctrl.sv
// Link global extended control register block with AHB-Lite slave
`timescale 1ns/100ps
module lgx_global_ctrl
	import lgx_pkg::*;
#(
	parameter int THR_BASE_CYC = lgx_pkg::LGX_THR_BASE_CYC,
	parameter int FULL_T0_CYC  = lgx_pkg::LGX_FULL_T0_CYC
) (
	input  wire logic                             CLK_I,
	input  wire logic                             RST_B_I,
	input  wire logic                             CE_I,
	input  wire logic                             HSEL_I,
	input  wire logic [lgx_pkg::LGX_ADDR_W-1:0]   HADDR_I,
	input  wire logic [1:0]                       HTRANS_I,
	input  wire logic                             HWRITE_I,
	input  wire logic [2:0]                       HSIZE_I,
	input  wire logic                             HREADY_I,
	input  wire logic [lgx_pkg::LGX_DATA_W-1:0]   HWDATA_I,
	output logic      [lgx_pkg::LGX_DATA_W-1:0]   HRDATA_O,
	output logic                                  HREADYOUT_O,
	output logic                                  HRESP_O,
	input  wire logic                             LINK_STOP_REQUEST_N_I,
	input  wire logic                             WARM_RESET_REQ_I,
	input  wire logic                             TRAIN0_START_I,
	input  wire logic                             TRAIN1_ACTIVE_I,
	output logic                                  FULL_TRAIN0_O,
	output logic      [lgx_pkg::LGX_T0C_W-1:0]    TRAIN0_CYCLES_O,
	output logic                                  RX_OFFSET_CAL_O,
	output logic      [1:0]                       IDLE_LANE_STATE_O,
	output logic                                  DISCONNECTED_O,
	output logic      [lgx_pkg::LGX_PHY_N*lgx_pkg::LGX_PHY_W-1:0] PHY_CFG_O
);
	import lgx_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	lgx_ctrl_s              ctrl_q;
	logic [LGX_PHY_AW-1:0]  phy_idx_q;
	logic                   wr_q;
	logic                   rd_q;
	logic [LGX_ADDR_W-1:0]  addr_q;
	logic                   addr_ok;
	logic                   wr_en;
	logic [1:0]             stop_s1_q;
	logic [1:0]             stop_s2_q;
	logic                   stop_old_q;
	logic                   warm_old_q;
	logic                   stop_fall;
	logic                   warm_rise;
	logic                   disc_ev;
	lgx_link_e              link_q;
	logic [LGX_DUR_W-1:0]   dur_q;
	logic [LGX_DUR_W-1:0]   thr_cyc;
	logic                   go_full;
	logic                   phy_wr;
	logic [LGX_PHY_W-1:0]   phy_rdata;
	logic                   pend_any;
	logic [LGX_DATA_W-1:0]  rd_mux;

	// ****************************************************************
	// AHB-Lite slave: writes complete with no wait, reads take one wait
	// ****************************************************************

	// Address phase capture
	assign addr_ok = HSEL_I && HREADY_I && HSIZE_I == 3'h2
		&& (HTRANS_I == LGX_HTRANS_NSQ || HTRANS_I == LGX_HTRANS_SEQ);
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= '0;
		end else if (CE_I) begin
			wr_q <= addr_ok && HWRITE_I;
			rd_q <= addr_ok && !HWRITE_I;
			if (addr_ok) begin
				addr_q <= HADDR_I;
			end
		end
	end

	// Ready, response and read data
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
			HRDATA_O    <= '0;
		end else if (CE_I) begin
			HRESP_O <= 1'b0;
			if (addr_ok && !HWRITE_I) begin
				HREADYOUT_O <= 1'b0;
			end else begin
				HREADYOUT_O <= 1'b1;
			end
			if (rd_q) begin
				HRDATA_O <= rd_mux;
			end
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_mux = '0;
		case (addr_q)
			LGX_OFF_CTRL:   rd_mux[LGX_CTRL_W-1:0] = ctrl_q;
			LGX_OFF_PHYIDX: rd_mux[LGX_PHY_AW-1:0] = phy_idx_q;
			LGX_OFF_PHYDAT: rd_mux[LGX_PHY_W-1:0] = phy_rdata;
			LGX_OFF_STATUS: begin
				rd_mux[LGX_ST_DISC]        = DISCONNECTED_O;
				rd_mux[LGX_ST_FULL]        = FULL_TRAIN0_O;
				rd_mux[LGX_ST_PEND]        = pend_any;
				rd_mux[LGX_ST_LANE +: 2]   = IDLE_LANE_STATE_O;
			end
			default: rd_mux = '0;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	assign wr_en = CE_I && wr_q;

	// Control register; reserved bits stay zero
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_q <= LGX_CTRL_RST;
		end else if (wr_en && addr_q == LGX_OFF_CTRL) begin
			ctrl_q        <= lgx_ctrl_s'(HWDATA_I[LGX_CTRL_W-1:0]);
			ctrl_q.rsvd_a <= '0;
			ctrl_q.rsvd_b <= '0;
		end
	end

	// Phy register index
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			phy_idx_q <= '0;
		end else if (wr_en && addr_q == LGX_OFF_PHYIDX) begin
			phy_idx_q <= HWDATA_I[LGX_PHY_AW-1:0];
		end
	end

	assign phy_wr = wr_en && addr_q == LGX_OFF_PHYDAT;

	// ****************************************************************
	// Link event synchronisers
	// ****************************************************************

	// Two stages for the stop pin and the warm reset request
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			stop_s1_q  <= 2'h1;
			stop_s2_q  <= 2'h1;
			stop_old_q <= 1'b1;
			warm_old_q <= 1'b0;
		end else if (CE_I) begin
			stop_s1_q  <= {WARM_RESET_REQ_I, LINK_STOP_REQUEST_N_I};
			stop_s2_q  <= stop_s1_q;
			stop_old_q <= stop_s2_q[0];
			warm_old_q <= stop_s2_q[1];
		end
	end

	assign stop_fall = stop_old_q && !stop_s2_q[0];
	assign warm_rise = !warm_old_q && stop_s2_q[1];
	assign disc_ev   = CE_I && (stop_fall || warm_rise);

	// ****************************************************************
	// Disconnect measurement and training-0 choice
	// ****************************************************************

	// Link state
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			link_q <= LGX_LINK_UP;
		end else if (CE_I) begin
			case (link_q)
				LGX_LINK_UP: begin
					if (stop_fall) link_q <= LGX_LINK_STOPPED;
				end
				LGX_LINK_STOPPED: begin
					if (stop_s2_q[0]) link_q <= LGX_LINK_WAIT_T0;
				end
				LGX_LINK_WAIT_T0: begin
					if (TRAIN0_START_I) link_q <= LGX_LINK_UP;
				end
				default: link_q <= LGX_LINK_UP;
			endcase
		end
	end

	// Duration counter, saturating
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			dur_q <= '0;
		end else if (CE_I) begin
			if (link_q == LGX_LINK_UP) begin
				dur_q <= '0;
			end else if (dur_q != '1) begin
				dur_q <= dur_q + 1'b1;
			end
		end
	end

	// Threshold decode: base doubled per code step
	always_comb begin
		if (ctrl_q.thresh == 3'h0) begin
			thr_cyc = '0;
		end else begin
			thr_cyc = LGX_DUR_W'(THR_BASE_CYC) << (ctrl_q.thresh - 3'h1);
		end
		go_full = ctrl_q.thresh != 3'h0 && dur_q >= thr_cyc;
	end

	// Training-0 decision latched when training 0 is about to start
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			FULL_TRAIN0_O   <= 1'b0;
			TRAIN0_CYCLES_O <= '0;
		end else if (CE_I && TRAIN0_START_I && link_q == LGX_LINK_WAIT_T0) begin
			FULL_TRAIN0_O <= go_full;
			if (go_full) begin
				TRAIN0_CYCLES_O <= LGX_T0C_W'(FULL_T0_CYC);
			end else begin
				TRAIN0_CYCLES_O <= lgx_t0_cycles(ctrl_q.t0);
			end
		end
	end

	// ****************************************************************
	// Link side outputs
	// ****************************************************************

	// Lane state, calibration gate and disconnect flag
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			IDLE_LANE_STATE_O <= LGX_CTRL_RST.lane;
			RX_OFFSET_CAL_O   <= 1'b0;
			DISCONNECTED_O    <= 1'b0;
		end else if (CE_I) begin
			if (disc_ev) begin
				IDLE_LANE_STATE_O <= ctrl_q.lane;
			end
			RX_OFFSET_CAL_O <= ctrl_q.rxcal && TRAIN1_ACTIVE_I;
			DISCONNECTED_O  <= link_q != LGX_LINK_UP || stop_fall;
		end
	end

	// Phy shadow
	lgx_phy_shadow u_shadow (
		.clk_i      (CLK_I),
		.rst_b_i    (RST_B_I),
		.ce_i       (CE_I),
		.wr_i       (phy_wr),
		.waddr_i    (phy_idx_q),
		.wdata_i    (HWDATA_I[LGX_PHY_W-1:0]),
		.raddr_i    (phy_idx_q),
		.imm_i      (ctrl_q.imm),
		.apply_i    (disc_ev),
		.rdata_o    (phy_rdata),
		.eff_o      (PHY_CFG_O),
		.pend_any_o (pend_any)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	hold_pend_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		phy_wr && !ctrl_q.imm && !disc_ev |=> $stable(PHY_CFG_O))
		else $error("pending phy write reached the phy early");

	read_eff_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		!ctrl_q.imm |-> phy_rdata == PHY_CFG_O[phy_idx_q*LGX_PHY_W +: LGX_PHY_W])
		else $error("phy read does not show the value in effect");

	imm_pass_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		phy_wr && ctrl_q.imm |=> PHY_CFG_O[$past(phy_idx_q)*LGX_PHY_W +: LGX_PHY_W]
			== $past(HWDATA_I[LGX_PHY_W-1:0]) && phy_rdata == $past(HWDATA_I[LGX_PHY_W-1:0]))
		else $error("immediate phy write not passed through");

	short_stop_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CE_I && TRAIN0_START_I && link_q == LGX_LINK_WAIT_T0 && ctrl_q.thresh == 3'h0
		|=> !FULL_TRAIN0_O && TRAIN0_CYCLES_O == lgx_t0_cycles($past(ctrl_q.t0)))
		else $error("threshold zero did not use programmed time");

	dur_count_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CE_I && link_q != LGX_LINK_UP && dur_q != '1 ##1 CE_I |-> dur_q == $past(dur_q) + 1'b1)
		else $error("disconnect duration not counting");

	long_stop_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CE_I && TRAIN0_START_I && link_q == LGX_LINK_WAIT_T0 && ctrl_q.thresh == 3'h1
		&& dur_q >= LGX_DUR_W'(THR_BASE_CYC)
		|=> FULL_TRAIN0_O && TRAIN0_CYCLES_O == LGX_T0C_W'(FULL_T0_CYC))
		else $error("long stop did not force full training");

	cal_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		RX_OFFSET_CAL_O |-> $past(ctrl_q.rxcal) && $past(TRAIN1_ACTIVE_I))
		else $error("calibration outside enabled training 1");

	lane_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		!disc_ev |=> $stable(IDLE_LANE_STATE_O))
		else $error("lane state changed without disconnect");

	t0_rsvd_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CE_I && TRAIN0_START_I && link_q == LGX_LINK_WAIT_T0 && !go_full
		&& ctrl_q.t0[5:4] == 2'h3
		|=> TRAIN0_CYCLES_O <= LGX_T0C_W'(LGX_T0_LOW_MAX * (LGX_STEP3_NS / LGX_CLK_NS)))
		else $error("training-0 time beyond the top step");

	apply_all_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		disc_ev && !phy_wr |=> !pend_any)
		else $error("pending phy writes not applied at disconnect");

	disc_flag_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CE_I && stop_fall |=> DISCONNECTED_O)
		else $error("link stop not flagged as disconnect");

	lane_apply_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		disc_ev |=> IDLE_LANE_STATE_O == $past(ctrl_q.lane))
		else $error("lane state not applied at disconnect");

	prog_time_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CE_I && TRAIN0_START_I && link_q == LGX_LINK_WAIT_T0 && !go_full
		|=> !FULL_TRAIN0_O && TRAIN0_CYCLES_O == lgx_t0_cycles($past(ctrl_q.t0)))
		else $error("short stop did not use programmed time");

endmodule : lgx_global_ctrl

// File: src/lgx_phy_shadow.sv
// Phy register shadow: pending writes, effective values and disconnect-time apply
`timescale 1ns/100ps
module lgx_phy_shadow
	import lgx_pkg::*;
(
	input  wire logic                             clk_i,
	input  wire logic                             rst_b_i,
	input  wire logic                             ce_i,
	input  wire logic                             wr_i,
	input  wire logic [lgx_pkg::LGX_PHY_AW-1:0]   waddr_i,
	input  wire logic [lgx_pkg::LGX_PHY_W-1:0]    wdata_i,
	input  wire logic [lgx_pkg::LGX_PHY_AW-1:0]   raddr_i,
	input  wire logic                             imm_i,
	input  wire logic                             apply_i,
	output logic      [lgx_pkg::LGX_PHY_W-1:0]    rdata_o,
	output logic      [lgx_pkg::LGX_PHY_N*lgx_pkg::LGX_PHY_W-1:0] eff_o,
	output logic                                  pend_any_o
);
	import lgx_pkg::*;

	logic [LGX_PHY_W-1:0] pend_q [LGX_PHY_N];
	logic [LGX_PHY_W-1:0] eff_q  [LGX_PHY_N];
	logic [LGX_PHY_N-1:0] valid_q;

	// Latest written value of each entry
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < LGX_PHY_N; i++) pend_q[i] <= '0;
		end else if (ce_i && wr_i) begin
			pend_q[waddr_i] <= wdata_i;
		end
	end

	// Pending flags; a write in the apply cycle stays pending unless immediate
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			valid_q <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < LGX_PHY_N; i++) begin
				if (wr_i && waddr_i == LGX_PHY_AW'(i)) begin
					valid_q[i] <= !imm_i;
				end else if (apply_i) begin
					valid_q[i] <= 1'b0;
				end
			end
		end
	end

	// Effective values seen by the phy
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < LGX_PHY_N; i++) eff_q[i] <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < LGX_PHY_N; i++) begin
				if (wr_i && imm_i && waddr_i == LGX_PHY_AW'(i)) begin
					eff_q[i] <= wdata_i;
				end else if (apply_i && valid_q[i]) begin
					eff_q[i] <= pend_q[i];
				end
			end
		end
	end

	// Read view and flat outputs
	always_comb begin
		rdata_o = imm_i ? pend_q[raddr_i] : eff_q[raddr_i];
		for (int i = 0; i < LGX_PHY_N; i++) eff_o[i*LGX_PHY_W +: LGX_PHY_W] = eff_q[i];
	end
	assign pend_any_o = |valid_q;

endmodule : lgx_phy_shadow

// File: src/lgx_pkg.sv
// Shared constants, types and helpers for the link global extended control block
package lgx_pkg;

	// ****************************************************************
	// Bus and register map
	// ****************************************************************
	localparam int          LGX_DATA_W     = 32;
	localparam int          LGX_ADDR_W     = 12;
	localparam logic [11:0] LGX_OFF_CTRL   = 12'h000;
	localparam logic [11:0] LGX_OFF_PHYIDX = 12'h004;
	localparam logic [11:0] LGX_OFF_PHYDAT = 12'h008;
	localparam logic [11:0] LGX_OFF_STATUS = 12'h00c;
	localparam logic [1:0]  LGX_HTRANS_NSQ = 2'h2;
	localparam logic [1:0]  LGX_HTRANS_SEQ = 2'h3;

	// ****************************************************************
	// Control register layout, bits 16:0, upper bits reserved
	// ****************************************************************
	localparam int LGX_CTRL_W = 17;
	typedef struct packed {
		logic       imm;     // phy_write_immediate
		logic [2:0] thresh;  // full_train0_threshold
		logic [2:0] rsvd_a;
		logic       rxcal;   // rx_offset_cal_enable
		logic       rsvd_b;
		logic [1:0] lane;    // idle_lane_state
		logic [5:0] t0;      // train0_duration
	} lgx_ctrl_s;
	localparam lgx_ctrl_s LGX_CTRL_RST = '{imm: 1'h0, thresh: 3'h0, rsvd_a: 3'h0,
		rxcal: 1'h0, rsvd_b: 1'h0, lane: 2'h0, t0: 6'h3a};

	// ****************************************************************
	// Phy shadow registers
	// ****************************************************************
	localparam int LGX_PHY_N  = 4;
	localparam int LGX_PHY_AW = 2;
	localparam int LGX_PHY_W  = 16;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int LGX_CLK_NS      = 20;
	localparam int LGX_STEP0_NS    = 100;
	localparam int LGX_STEP1_NS    = 500;
	localparam int LGX_STEP2_NS    = 2000;
	localparam int LGX_STEP3_NS    = 20000;
	localparam int LGX_THR_BASE_NS = 400000;
	localparam int LGX_FULL_T0_NS  = 200000;
	localparam int LGX_THR_BASE_CYC = LGX_THR_BASE_NS / LGX_CLK_NS;
	localparam int LGX_FULL_T0_CYC  = LGX_FULL_T0_NS / LGX_CLK_NS;
	localparam int LGX_T0_LOW_MAX   = 10;
	localparam int LGX_DUR_W        = 24;
	localparam int LGX_T0C_W        = 14;

	// Status register bit positions
	localparam int LGX_ST_DISC = 0;
	localparam int LGX_ST_FULL = 1;
	localparam int LGX_ST_PEND = 2;
	localparam int LGX_ST_LANE = 6;

	typedef enum logic [1:0] {LGX_LINK_UP, LGX_LINK_STOPPED, LGX_LINK_WAIT_T0} lgx_link_e;

	// Training-0 time in clock cycles; reserved low values clamp to the top step
	function automatic logic [LGX_T0C_W-1:0] lgx_t0_cycles(input logic [5:0] t0);
		logic [3:0] low;
		int         cyc;
		low = t0[3:0];
		cyc = 0;
		case (t0[5:4])
			2'h0: cyc = int'(low) * (LGX_STEP0_NS / LGX_CLK_NS);
			2'h1: cyc = int'(low) * (LGX_STEP1_NS / LGX_CLK_NS);
			2'h2: cyc = int'(low) * (LGX_STEP2_NS / LGX_CLK_NS);
			default: begin
				if (int'(low) > LGX_T0_LOW_MAX) begin
					cyc = LGX_T0_LOW_MAX * (LGX_STEP3_NS / LGX_CLK_NS);
				end else begin
					cyc = int'(low) * (LGX_STEP3_NS / LGX_CLK_NS);
				end
			end
		endcase
		return cyc[LGX_T0C_W-1:0];
	endfunction : lgx_t0_cycles

endpackage : lgx_pkg

// File: test/lgx_link_model.sv
// Link training partner: drives stop, warm reset and training pins of the block
`timescale 1ns/100ps
module lgx_link_model (
	input  wire logic clk_i,
	output logic      stop_n_o,
	output logic      warm_o,
	output logic      t0_start_o,
	output logic      t1_act_o
);
	// ****************************************************************
	// Pin sequences
	// ****************************************************************
	// Idle levels at time zero: stop released, no warm reset, no training
	initial begin
		stop_n_o = 1'b1;
		warm_o = 1'b0;
		t0_start_o = 1'b0;
		t1_act_o = 1'b0;
	end

	// Stop held n cycles, released, then training 0 and training 1 follow
	task automatic stop_cycle(input int n);
		@(posedge clk_i);
		stop_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		stop_n_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		t0_start_o <= 1'b1;
		@(posedge clk_i);
		t0_start_o <= 1'b0;
		t1_act_o <= 1'b1;
		repeat (8) @(posedge clk_i);
		t1_act_o <= 1'b0;
	endtask : stop_cycle

	// Warm reset request held long enough to pass the synchroniser
	task automatic warm_pulse();
		@(posedge clk_i);
		warm_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		warm_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : warm_pulse
endmodule : lgx_link_model

// File: test/testbench.sv
// Self-checking bench for the link global control block
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch at %0t: got %h want %h", $time, (g), (e)); end end
module testbench;
	import lgx_pkg::*;
	localparam int THR  = 20;
	localparam int FULL = 50;
	logic        clk;
	logic        rst_b;
	logic        ce;
	logic        hwrite;
	logic        hready;
	logic        hresp;
	logic [1:0]  htrans;
	logic [11:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        stop_n;
	logic        warm;
	logic        t0s;
	logic        t1a;
	logic        full;
	logic        rxc;
	logic        disc;
	logic [1:0]  lane;
	logic [13:0] t0c;
	logic [63:0] phy;
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc = 0;

	// ****************************************************************
	// Clock, design and partner
	// ****************************************************************
	// Free-running clock
	initial clk = 1'b0;
	always #10 clk = ~clk;

	lgx_global_ctrl #(.THR_BASE_CYC(THR), .FULL_T0_CYC(FULL)) dut_u (
		.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .HSEL_I(1'b1), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
		.HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.LINK_STOP_REQUEST_N_I(stop_n), .WARM_RESET_REQ_I(warm), .TRAIN0_START_I(t0s),
		.TRAIN1_ACTIVE_I(t1a), .FULL_TRAIN0_O(full), .TRAIN0_CYCLES_O(t0c),
		.RX_OFFSET_CAL_O(rxc), .IDLE_LANE_STATE_O(lane), .DISCONNECTED_O(disc),
		.PHY_CFG_O(phy));

	lgx_link_model link_u (.clk_i(clk), .stop_n_o(stop_n), .warm_o(warm),
		.t0_start_o(t0s), .t1_act_o(t1a));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// One single-word transfer; waits for hready in both phases
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		htrans <= LGX_HTRANS_NSQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		`CHK(hresp, 1'b0)
	endtask : bus

	// Expected training-0 cycles from the field encoding
	function automatic logic [13:0] exp_t0(input logic [5:0] t);
		int lo;
		int s;
		lo = (t[5:4] == 2'h3 && t[3:0] > 4'ha) ? 10 : int'(t[3:0]);
		s = (t[5:4] == 2'h0) ? 5 : (t[5:4] == 2'h1) ? 25 : (t[5:4] == 2'h2) ? 100 : 1000;
		return 14'(lo * s);
	endfunction : exp_t0

	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Reset values of control, status and outputs; unmapped read
	task automatic t_reset();
		logic [31:0] r;
		bus(1'b0, LGX_OFF_CTRL, 32'h0, r);
		`CHK(r, 32'h0000003a)
		bus(1'b0, LGX_OFF_STATUS, 32'h0, r);
		`CHK(r, 32'h0)
		bus(1'b0, 12'h010, 32'h0, r);
		`CHK(r, 32'h0)
		`CHK(lane, 2'h0)
		`CHK(rxc, 1'b0)
		$display("test reset done");
	endtask : t_reset

	// Held phy writes and lane state apply together at a link stop
	task automatic t_pending();
		logic [31:0] r;
		bus(1'b1, LGX_OFF_PHYIDX, 32'h1, r);
		bus(1'b1, LGX_OFF_PHYDAT, 32'h1234, r);
		bus(1'b1, LGX_OFF_PHYIDX, 32'h3, r);
		bus(1'b1, LGX_OFF_PHYDAT, 32'h5678, r);
		bus(1'b1, LGX_OFF_CTRL, 32'h0000c0fa, r);
		bus(1'b0, LGX_OFF_CTRL, 32'h0, r);
		`CHK(r, 32'h0000c0fa)
		bus(1'b0, LGX_OFF_PHYDAT, 32'h0, r);
		`CHK(r, 32'h0)
		bus(1'b0, LGX_OFF_STATUS, 32'h0, r);
		`CHK(r, 32'h00000004)
		`CHK(phy, 64'h0)
		`CHK(lane, 2'h0)
		fork
			link_u.stop_cycle(50);
			begin
				repeat (10) @(posedge clk);
				`CHK(disc, 1'b1)
			end
		join
		`CHK(phy, 64'h5678_0000_1234_0000)
		`CHK(lane, 2'h3)
		`CHK(full, 1'b0)
		`CHK(t0c, exp_t0(6'h3a))
		bus(1'b0, LGX_OFF_STATUS, 32'h0, r);
		`CHK(r, 32'h000000c0)
		bus(1'b0, LGX_OFF_PHYDAT, 32'h0, r);
		`CHK(r, 32'h5678)
		$display("test pending done");
	endtask : t_pending

	// Immediate mode passes phy writes at once
	task automatic t_imm();
		logic [31:0] r;
		bus(1'b1, LGX_OFF_CTRL, 32'h0001003a, r);
		bus(1'b1, LGX_OFF_PHYIDX, 32'h2, r);
		bus(1'b1, LGX_OFF_PHYDAT, 32'hbeef, r);
		repeat (2) @(posedge clk);
		`CHK(phy[47:32], 16'hbeef)
		bus(1'b0, LGX_OFF_PHYDAT, 32'h0, r);
		`CHK(r, 32'hbeef)
		$display("test immediate done");
	endtask : t_imm

	// Every threshold encoding, just below and above, with varied training times
	task automatic t_thresh();
		logic [31:0] r;
		logic [5:0]  t0s_tab [8];
		int          thr;
		t0s_tab = '{6'h0a, 6'h1f, 6'h2f, 6'h3a, 6'h38, 6'h00, 6'h35, 6'h10};
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, LGX_OFF_CTRL, {16'h0, k[2:0], 7'h0, t0s_tab[k]}, r);
			thr = (k == 0) ? 40 : THR << (k - 1);
			for (int lg = 0; lg < 2; lg++) begin
				link_u.stop_cycle((lg == 1) ? thr : thr - 10);
				`CHK(full, (lg == 1 && k != 0))
				`CHK(t0c, (lg == 1 && k != 0) ? 14'(FULL) : exp_t0(t0s_tab[k]))
			end
		end
		$display("test threshold done");
	endtask : t_thresh

	// Receiver calibration follows the enable bit during training 1
	task automatic t_rxcal();
		logic [31:0] r;
		for (int e = 1; e >= 0; e--) begin
			bus(1'b1, LGX_OFF_CTRL, {22'h0, e[0], 9'h03a}, r);
			fork
				link_u.stop_cycle(30);
				begin
					repeat (40) @(posedge clk);
					`CHK(rxc, e[0])
				end
			join
			repeat (2) @(posedge clk);
			`CHK(rxc, 1'b0)
		end
		$display("test calibration done");
	endtask : t_rxcal

	// Warm reset applies held writes and the scrambled lane state
	task automatic t_warm();
		logic [31:0] r;
		bus(1'b1, LGX_OFF_CTRL, 32'h000000ba, r);
		bus(1'b1, LGX_OFF_PHYIDX, 32'h0, r);
		bus(1'b1, LGX_OFF_PHYDAT, 32'h0f0f, r);
		`CHK(phy[15:0], 16'h0)
		link_u.warm_pulse();
		`CHK(phy[15:0], 16'h0f0f)
		`CHK(lane, 2'h2)
		$display("test warm done");
	endtask : t_warm

	// ****************************************************************
	// Main sequence and timeout
	// ****************************************************************
	// Reset, then every scenario in turn
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		htrans = 2'h0;
		haddr = 12'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_pending();
		t_imm();
		t_thresh();
		t_rxcal();
		t_warm();
		conclude();
	end

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			conclude();
		end
	end
endmodule : testbench
